// ==== hdl/mode_control_spi_slave.sv ====
// mode sequencer with serial slave, reset line and interrupt output
// assumes serial pins and analog comparators are asynchronous to core_clk
//
// Notes on behaviour
// - output on rising, sample on falling clock
// - serial output undriven while select high
// - select rising edge ends and latches frame
// - valid frame holds exactly eight bits
// - select rising edge wakes from stop
// - pwm drives switches only when enabled, active
// - reset line bidirectional, release enters normal request
// - interrupt low until status read over serial
// - grounded strap disables watchdog
// - wake inputs readable; change wakes stop, sleep
// - cyclic sense pulses switch, compares samples
// - muxed wake input disabled for read, wake
// - regulator limited in stop, off in sleep
// - stop wake interrupts; sleep wake resets
// - mode bits in mode register select mode
// - power up holds reset low 1 ms
// - reset conditions force reset mode in normal request, normal; in stop only regulator low does
// - normal request keeps regulator, reset high, rx only
// - normal request times out after 150 ms
// - grounded strap skips to normal mode
// - normal mode supply and thermal interrupts
// - no interrupts while reset line low
// - select and reset-line wakes raise no interrupt
`timescale 1ns/1ps
module mode_control_spi_slave (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       sclk,
  input  wire logic       cs_b,
  input  wire logic       mosi,
  output logic            miso_out,
  output logic            miso_oe,
  input  wire logic       reset_line_in,
  output logic            reset_line_out,
  output logic            reset_line_oe,
  output logic            irq_b,
  input  wire logic       watchdog_strap_pin,
  input  wire logic       watchdog_fail,
  input  wire logic       regulator_low,
  input  wire logic       pwm_control_input,
  input  wire logic       wake_input_one,
  input  wire logic       wake_input_two,
  input  wire logic       supply_over,
  input  wire logic       supply_under,
  input  wire logic       thermal_shutdown,
  input  wire logic       thermal_prewarn,
  input  wire logic       cyclic_tick,
  output logic            high_side_switch,
  output logic            low_side_switch_one,
  output logic            low_side_switch_two,
  output logic            regulator_on,
  output logic            regulator_limited,
  output logic            lin_rx_only,
  output logic [4:0]      mode_state
);
  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  localparam int unsigned NSYNC = 13;
  // select and reset line rest high, no false edge after reset
  localparam logic [NSYNC-1:0] SYNC_IDLE = 13'ha00;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  assign async_in = {sclk, cs_b, mosi, reset_line_in, watchdog_strap_pin,
                     pwm_control_input, wake_input_one, wake_input_two,
                     supply_over, supply_under, thermal_shutdown,
                     thermal_prewarn, regulator_low};
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= SYNC_IDLE;
      sync2_reg <= SYNC_IDLE;
    end else begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end
  logic sclk_s, cs_s, mosi_s, rline_s, strap_s, pwm_s, w1_s, w2_s;
  logic sov_s, suv_s, tsd_s, tpw_s, rlow_s;
  assign {sclk_s, cs_s, mosi_s, rline_s, strap_s, pwm_s, w1_s, w2_s,
          sov_s, suv_s, tsd_s, tpw_s, rlow_s} = sync2_reg;

  ////////////////////////////////////////////////////////////////////////
  // edge detection
  logic sclk_d_reg, cs_d_reg;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_d_reg <= 1'b0;
      cs_d_reg   <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_d_reg   <= cs_s;
    end
  end
  logic sclk_rise, sclk_fall, cs_rise, cs_fall;
  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign sclk_fall = ~sclk_s & sclk_d_reg;
  assign cs_rise   = cs_s & ~cs_d_reg;
  assign cs_fall   = ~cs_s & cs_d_reg;

  ////////////////////////////////////////////////////////////////////////
  // serial shifter
  logic [7:0] rx_reg, tx_reg;
  logic [3:0] bits_reg;
  logic [7:0] status_word;
  logic       frame_ok;
  assign frame_ok = cs_rise &&
                    (bits_reg == mode_ctl_pkg::FRAME_BITS);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_reg   <= 8'h00;
      tx_reg   <= 8'h00;
      bits_reg <= 4'h0;
    end else if (cs_fall) begin
      tx_reg   <= status_word;
      bits_reg <= 4'h0;
    end else if (!cs_s && sclk_fall) begin
      rx_reg   <= {rx_reg[6:0], mosi_s};
      bits_reg <= (bits_reg == 4'hf) ? bits_reg : bits_reg + 4'h1;
    end else if (!cs_s && sclk_rise && bits_reg != 4'h0) begin
      tx_reg   <= {tx_reg[6:0], 1'b0};
    end
  end
  assign miso_out = tx_reg[7];
  assign miso_oe  = ~cs_s;

  ////////////////////////////////////////////////////////////////////////
  // register writes on frame end
  logic [2:0] fr_addr;
  logic [4:0] fr_data;
  assign fr_addr = rx_reg[mode_ctl_pkg::ADDR_MSB:mode_ctl_pkg::ADDR_LSB];
  assign fr_data = rx_reg[4:0];
  logic [1:0] mode_control_reg;
  logic [4:0] timing_control_reg, high_side_control_reg;
  logic [4:0] low_side_control_reg, mux_reg;
  logic       mode_write, irq_read;
  assign mode_write = frame_ok && fr_addr == mode_ctl_pkg::ADDR_MODE;
  assign irq_read   = frame_ok && fr_addr == mode_ctl_pkg::ADDR_IRQRD;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_control_reg      <= 2'h3;
      timing_control_reg    <= 5'h00;
      high_side_control_reg <= 5'h00;
      low_side_control_reg  <= 5'h00;
      mux_reg               <= 5'h00;
    end else if (frame_ok) begin
      if (fr_addr == mode_ctl_pkg::ADDR_MODE)
        mode_control_reg <= fr_data[1:0];
      if (fr_addr == mode_ctl_pkg::ADDR_TIMING)
        timing_control_reg <= fr_data;
      if (fr_addr == mode_ctl_pkg::ADDR_HS)
        high_side_control_reg <= fr_data;
      if (fr_addr == mode_ctl_pkg::ADDR_LS)
        low_side_control_reg <= fr_data;
      if (fr_addr == mode_ctl_pkg::ADDR_MUX)
        mux_reg <= fr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wake inputs, muxed ones masked
  logic w1_en, w2_en, w1_dig, w2_dig;
  assign w1_en  = ~mux_reg[0];
  assign w2_en  = ~mux_reg[1];
  assign w1_dig = w1_s & w1_en;
  assign w2_dig = w2_s & w2_en;
  logic w1_d_reg, w2_d_reg, cyc1_reg, cyc2_reg;
  logic cyc_active;
  mode_ctl_pkg::mode_state_t state_reg, state_next;
  logic low_power;
  assign low_power = state_reg == mode_ctl_pkg::ST_STOP ||
                     state_reg == mode_ctl_pkg::ST_SLEEP;
  assign cyc_active = low_power &
                      high_side_control_reg[mode_ctl_pkg::CS_PERIOD_BIT];
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      w1_d_reg <= 1'b0;
      w2_d_reg <= 1'b0;
      cyc1_reg <= 1'b0;
      cyc2_reg <= 1'b0;
    end else begin
      w1_d_reg <= w1_dig;
      w2_d_reg <= w2_dig;
      if (cyclic_tick) begin
        cyc1_reg <= w1_dig;
        cyc2_reg <= w2_dig;
      end
    end
  end
  logic wake_change, wake_cyclic, lx_wake;
  assign wake_change = (w1_dig ^ w1_d_reg) | (w2_dig ^ w2_d_reg);
  assign wake_cyclic = cyclic_tick &
                       ((w1_dig ^ cyc1_reg) | (w2_dig ^ cyc2_reg));
  assign lx_wake = cyc_active ? wake_cyclic : wake_change;

  ////////////////////////////////////////////////////////////////////////
  // mode state machine
  logic [mode_ctl_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic rst_cond, timeout, hold_done, strap_off;
  assign strap_off = ~strap_s;
  assign hold_done = cnt_reg ==
    mode_ctl_pkg::CNT_W'(mode_ctl_pkg::RESET_HOLD_CYC - 1);
  assign timeout = cnt_reg ==
    mode_ctl_pkg::CNT_W'(mode_ctl_pkg::NREQ_TIMEOUT_CYC - 1);
  // own drive stays visible through the synchroniser for two cycles
  logic [1:0] drv_pipe_reg;
  logic       in_reset, line_ext_low;
  assign in_reset = state_reg == mode_ctl_pkg::ST_RESET;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) drv_pipe_reg <= 2'h3;
    else drv_pipe_reg <= {drv_pipe_reg[0], in_reset};
  end
  assign line_ext_low = ~rline_s & ~in_reset & ~|drv_pipe_reg;
  assign rst_cond = rlow_s | (watchdog_fail & ~strap_off) |
                    line_ext_low;
  logic stop_wake_irq;
  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg + 1'b1;
    stop_wake_irq = 1'b0;
    unique case (state_reg)
      mode_ctl_pkg::ST_RESET: begin
        if (rst_cond) cnt_next = '0;
        else if (hold_done) begin
          state_next = strap_off ? mode_ctl_pkg::ST_NORMAL
                                 : mode_ctl_pkg::ST_NREQ;
          cnt_next   = '0;
        end
      end
      mode_ctl_pkg::ST_NREQ, mode_ctl_pkg::ST_NORMAL: begin
        if (rst_cond || (state_reg == mode_ctl_pkg::ST_NREQ && timeout)) begin
          state_next = mode_ctl_pkg::ST_RESET;
          cnt_next   = '0;
        end else if (mode_write) begin // timer runs on
          if (fr_data[1:0] == mode_ctl_pkg::MODE_NORMAL)
            state_next = mode_ctl_pkg::ST_NORMAL;
          else if (state_reg == mode_ctl_pkg::ST_NORMAL &&
                   fr_data[1:0] == mode_ctl_pkg::MODE_STOP)
            state_next = mode_ctl_pkg::ST_STOP;
          else if (state_reg == mode_ctl_pkg::ST_NORMAL &&
                   fr_data[1:0] == mode_ctl_pkg::MODE_SLEEP)
            state_next = mode_ctl_pkg::ST_SLEEP;
        end
      end
      mode_ctl_pkg::ST_STOP: begin
        cnt_next = '0;
        if (rlow_s) state_next = mode_ctl_pkg::ST_RESET;
        else if (cs_rise || ~rline_s)
          state_next = mode_ctl_pkg::ST_NREQ;
        else if (lx_wake) begin
          state_next    = mode_ctl_pkg::ST_NREQ;
          stop_wake_irq = 1'b1;
        end
      end
      mode_ctl_pkg::ST_SLEEP: begin
        cnt_next = '0;
        if (lx_wake) state_next = mode_ctl_pkg::ST_RESET;
      end
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= mode_ctl_pkg::ST_RESET;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end
  assign mode_state = state_reg;

  ////////////////////////////////////////////////////////////////////////
  // interrupt sources, set wins over read clear
  logic [4:0] irq_src_reg, irq_set, irq_next;
  logic       active, rline_drv;
  assign active = state_reg == mode_ctl_pkg::ST_NREQ ||
                  state_reg == mode_ctl_pkg::ST_NORMAL;
  assign irq_set = (rline_drv || ~rline_s) ? 5'h00 :
    {stop_wake_irq, {4{active}} & {sov_s, suv_s, tsd_s, tpw_s}};
  assign irq_next = irq_set |
    ((irq_read || rline_drv) ? 5'h00 : irq_src_reg);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) irq_src_reg <= 5'h00;
    else irq_src_reg <= irq_next;
  end
  assign irq_b = ~|irq_src_reg;
  assign status_word = {1'b0, w1_dig, w2_dig, irq_src_reg};

  ////////////////////////////////////////////////////////////////////////
  // pins and switches
  assign rline_drv      = state_reg == mode_ctl_pkg::ST_RESET;
  assign reset_line_out = 1'b0;
  assign reset_line_oe  = rline_drv;
  logic hs_on, ls_on;
  assign hs_on = high_side_control_reg[mode_ctl_pkg::PWM_BIT] ? pwm_s
                 : high_side_control_reg[mode_ctl_pkg::ON_BIT];
  assign ls_on = low_side_control_reg[mode_ctl_pkg::PWM_BIT] ? pwm_s
                 : low_side_control_reg[mode_ctl_pkg::ON_BIT];
  assign high_side_switch    = (active & hs_on) |
                               (cyc_active & cyclic_tick);
  assign low_side_switch_one = active & ls_on & low_side_control_reg[3];
  assign low_side_switch_two = active & ls_on & low_side_control_reg[2];
  assign regulator_on      = state_reg != mode_ctl_pkg::ST_SLEEP;
  assign regulator_limited = state_reg == mode_ctl_pkg::ST_STOP;
  assign lin_rx_only       = state_reg != mode_ctl_pkg::ST_NORMAL;
endmodule

// ==== hdl/mode_ctl_pkg.sv ====
// constants for the mode sequencer and serial slave
// assumes a 40 MHz core clock
package mode_ctl_pkg;
  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned RESET_HOLD_US = 1000;
  localparam int unsigned NREQ_TIMEOUT_US = 150000;
  localparam int unsigned RESET_HOLD_CYC =
    (RESET_HOLD_US * (CLK_HZ / 1000000));
  localparam int unsigned NREQ_TIMEOUT_CYC =
    (NREQ_TIMEOUT_US * (CLK_HZ / 1000000));
  localparam int unsigned CNT_W = 24;
  localparam logic [3:0] FRAME_BITS = 4'h8;
  // frame: [7:5] register select, [4:0] data
  localparam int unsigned ADDR_MSB = 7;
  localparam int unsigned ADDR_LSB = 5;
  localparam logic [2:0] ADDR_MODE   = 3'h0;
  localparam logic [2:0] ADDR_TIMING = 3'h1;
  localparam logic [2:0] ADDR_HS     = 3'h2;
  localparam logic [2:0] ADDR_LS     = 3'h3;
  localparam logic [2:0] ADDR_MUX    = 3'h4;
  localparam logic [2:0] ADDR_IRQRD  = 3'h5;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_STOP   = 2'h1;
  localparam logic [1:0] MODE_SLEEP  = 2'h2;
  localparam int unsigned CS_BIT  = 2;
  localparam int unsigned PWM_BIT = 1;
  localparam int unsigned ON_BIT  = 0;
  localparam int unsigned CS_PERIOD_BIT = 4;
  typedef enum logic [4:0] {
    ST_RESET  = 5'h01,
    ST_NREQ   = 5'h02,
    ST_NORMAL = 5'h04,
    ST_STOP   = 5'h08,
    ST_SLEEP  = 5'h10
  } mode_state_t;
endpackage

// ==== verification/mode_control_spi_slave_tb.sv ====
// bench for the mode sequencer and serial slave
// assumes the host model and the bound checker are compiled with it
`timescale 1ns/1ps
module mode_control_spi_slave_tb;
  logic       core_clk = 1'b0, rst_b = 1'b0, watchdog_strap_pin = 1'b1;
  logic       pwm_control_input = 1'b0, wake_input_one = 1'b0;
  logic       wake_input_two = 1'b0, supply_over = 1'b0, supply_under = 1'b0;
  logic       thermal_shutdown = 1'b0, thermal_prewarn = 1'b0;
  logic       regulator_low = 1'b0, watchdog_fail = 1'b0;
  logic [7:0] rx;
  int         bad_count = 0, compares = 0, cycles = 0;
  wire        sclk, cs_b, mosi, miso_out, miso_oe, reset_line_out, irq_b;
  wire        reset_line_oe, high_side_switch, low_side_switch_one;
  wire        low_side_switch_two, regulator_on, regulator_limited;
  wire        lin_rx_only;
  wire [4:0]  mode_state;
  wire        miso = miso_oe ? miso_out : 1'bz;
  wire        reset_line_in = reset_line_oe ? reset_line_out : 1'b1;
  // rows: frame, pwm level, high side, low side one, low side two
  logic [11:0] rows [8] = '{12'h414, 12'h420, 12'h42c, 12'h408,
                            12'h692, 12'h651, 12'h6eb, 12'h6e0};
  always #12.5 core_clk = ~core_clk;
  mode_control_spi_slave mode_control_spi_slave_inst (
    .core_clk, .rst_b, .sclk, .cs_b, .mosi, .miso_out, .miso_oe,
    .reset_line_in, .reset_line_out, .reset_line_oe, .irq_b,
    .watchdog_strap_pin, .watchdog_fail, .regulator_low,
    .pwm_control_input, .wake_input_one, .wake_input_two, .supply_over,
    .supply_under, .thermal_shutdown, .thermal_prewarn,
    .cyclic_tick(1'b0), .high_side_switch, .low_side_switch_one,
    .low_side_switch_two, .regulator_on, .regulator_limited,
    .lin_rx_only, .mode_state);
  spi_host_model spi_host_model_inst (.sclk, .cs_b, .mosi, .miso);
  //////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic frame(input logic [7:0] tx, input int nbits = 8);
    spi_host_model_inst.xfer(tx, nbits, rx);
    tick(1);
  endtask
  task automatic wait_mode(input logic [4:0] m);
    for (int n = 0; n < 400 && mode_state !== m; n++) tick(1);
    chk("mode", 8'(mode_state), 8'(m));
  endtask
  task automatic summarize;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 95000) begin
      bad_count++;
      summarize;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    tick(10);
    rst_b = 1'b1;
    tick(4);
    chk("reset_oe", 8'(reset_line_oe), 8'h01);
    chk("irq", 8'(irq_b), 8'h01);
    tick(39850);
    chk("mode", 8'(mode_state), 8'h01);
    wait_mode(mode_ctl_pkg::ST_NREQ);
    chk("nreq", 8'({regulator_on, lin_rx_only}), 8'h03);
    frame(8'h02);
    frame(8'h00, 7);
    chk("mode", 8'(mode_state), 8'h02);
    frame(8'h25);
    frame(8'h00);
    wait_mode(mode_ctl_pkg::ST_NORMAL);
    foreach (rows[i]) begin
      pwm_control_input = rows[i][3];
      frame(rows[i][11:4]);
      tick(4);
      chk("switch", 8'({high_side_switch, low_side_switch_one,
          low_side_switch_two}), 8'(rows[i][2:0]));
    end
    supply_over = 1'b1;
    supply_under = 1'b1;
    thermal_shutdown = 1'b1;
    thermal_prewarn = 1'b1;
    tick(8);
    supply_over = 1'b0;
    supply_under = 1'b0;
    thermal_shutdown = 1'b0;
    thermal_prewarn = 1'b0;
    tick(8);
    chk("irq", 8'(irq_b), 8'h00);
    frame(8'ha0);
    chk("status", rx, 8'h0f);
    chk("irq", 8'(irq_b), 8'h01);
    wake_input_one = 1'b1;
    tick(4);
    frame(8'ha0);
    chk("status", rx, 8'h40);
    frame(8'h81);
    frame(8'ha0);
    chk("status", rx, 8'h00);
    frame(8'h01);
    wait_mode(mode_ctl_pkg::ST_STOP);
    chk("limit", 8'(regulator_limited), 8'h01);
    wake_input_one = 1'b0;
    tick(20);
    chk("mode", 8'(mode_state), 8'h08);
    wake_input_two = 1'b1;
    wait_mode(mode_ctl_pkg::ST_NREQ);
    tick(2);
    chk("irq", 8'(irq_b), 8'h00);
    frame(8'ha0);
    chk("status", rx, 8'h30);
    frame(8'h00);
    frame(8'h80);
    frame(8'h01);
    wait_mode(mode_ctl_pkg::ST_STOP);
    frame(8'h00, 0);
    wait_mode(mode_ctl_pkg::ST_NREQ);
    chk("irq", 8'(irq_b), 8'h01);
    frame(8'h00);
    frame(8'h02);
    wait_mode(mode_ctl_pkg::ST_SLEEP);
    chk("reg_on", 8'(regulator_on), 8'h00);
    watchdog_strap_pin = 1'b0;
    wake_input_one = 1'b1;
    wait_mode(mode_ctl_pkg::ST_RESET);
    chk("reset_oe", 8'(reset_line_oe), 8'h01);
    tick(39990);
    wait_mode(mode_ctl_pkg::ST_NORMAL);
    watchdog_fail = 1'b1;
    tick(6);
    chk("mode", 8'(mode_state), 8'h04);
    watchdog_fail = 1'b0;
    regulator_low = 1'b1;
    wait_mode(mode_ctl_pkg::ST_RESET);
    chk("irq", 8'(irq_b), 8'h01);
    regulator_low = 1'b0;
    summarize;
  end
endmodule

// ==== verification/mode_ctl_sva.sv ====
// checker for the mode sequencer and serial slave ports
// assumes it is bound to mode_control_spi_slave
`timescale 1ns/1ps
module mode_ctl_sva (
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       cs_b,
  input wire logic       miso_oe,
  input wire logic       reset_line_oe,
  input wire logic       irq_b,
  input wire logic       watchdog_strap_pin,
  input wire logic       low_side_switch_one,
  input wire logic       low_side_switch_two,
  input wire logic       regulator_on,
  input wire logic       regulator_limited,
  input wire logic       lin_rx_only,
  input wire logic [4:0] mode_state
);
  localparam logic [4:0] RST  = mode_ctl_pkg::ST_RESET;
  localparam logic [4:0] NREQ = mode_ctl_pkg::ST_NREQ;
  localparam logic [4:0] NORM = mode_ctl_pkg::ST_NORMAL;
  localparam int         HOLD = mode_ctl_pkg::RESET_HOLD_CYC - 8;
  localparam int         NMAX = mode_ctl_pkg::NREQ_TIMEOUT_CYC + 8;
  logic [4:0]  prev_reg;
  int unsigned dwell_reg;
  wire         left_rst = prev_reg == RST && mode_state != RST;
  // cycles spent in the present mode
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_reg  <= RST;
      dwell_reg <= 0;
    end else begin
      prev_reg  <= mode_state;
      dwell_reg <= (mode_state == prev_reg) ? dwell_reg + 1 : 0;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence stop_cs_rise;
    mode_state == mode_ctl_pkg::ST_STOP && $rose(cs_b);
  endsequence
  sequence back_to_nreq;
    ##[1:8] mode_state == NREQ;
  endsequence
  miso_release_a: assert property (cs_b [*6] |-> !miso_oe)
    else $error("serial output driven while deselected");
  reset_drive_a: assert property (reset_line_oe == (mode_state == RST))
    else $error("reset line drive disagrees with mode");
  nreq_out_a: assert property (
    mode_state == NREQ |-> regulator_on && lin_rx_only)
    else $error("normal request outputs wrong");
  supply_mode_a: assert property (
    mode_state == mode_ctl_pkg::ST_STOP |-> regulator_limited)
    else $error("regulator not limited in stop");
  irq_quiet_a: assert property (reset_line_oe [*3] |-> irq_b)
    else $error("interrupt while reset line low");
  switch_gate_a: assert property (
    mode_state != NREQ && mode_state != NORM
      |-> !low_side_switch_one && !low_side_switch_two)
    else $error("low side switch on outside active modes");
  reset_hold_a: assert property (left_rst |-> dwell_reg >= HOLD)
    else $error("reset mode left too early");
  reset_exit_a: assert property (
    left_rst |-> mode_state == (watchdog_strap_pin ? NREQ : NORM))
    else $error("wrong mode after reset");
  nreq_limit_a: assert property (
    mode_state == NREQ |-> dwell_reg <= NMAX)
    else $error("normal request outlived its timer");
  stop_wake_a: assert property (
    stop_cs_rise |-> irq_b throughout back_to_nreq)
    else $error("select wake from stop misbehaved");
endmodule
bind mode_control_spi_slave mode_ctl_sva mode_ctl_sva_inst (
  .core_clk, .rst_b, .cs_b, .miso_oe, .reset_line_oe, .irq_b,
  .watchdog_strap_pin, .low_side_switch_one, .low_side_switch_two,
  .regulator_on, .regulator_limited, .lin_rx_only, .mode_state);

// ==== verification/spi_host_model.sv ====
// serial host model for the mode sequencer bench
// assumes the slave samples on falling sclk, drives miso when selected
`timescale 1ns/1ps
module spi_host_model (
  output logic     sclk,
  output logic     cs_b,
  output logic     mosi,
  input wire logic miso
);
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    mosi = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // one frame of nbits from bit 7 down, 200 ns serial clock
  task automatic xfer(input logic [7:0] tx, input int nbits,
                      output logic [7:0] rx);
    rx = 8'h00;
    cs_b = 1'b0;
    #100;
    for (int i = 7; i > 7 - nbits; i--) begin
      sclk = 1'b1;
      mosi = tx[i];
      #100;
      sclk = 1'b0;
      rx = {rx[6:0], miso};
      #100;
    end
    cs_b = 1'b1;
    mosi = ~mosi; // no stale bit after release
    #200;
  endtask
endmodule
